// >>> src/pis_pkg.sv
// Constants for the per-core private interrupt state registers
package pis_pkg;

  // ****************************************************
  // Register map within the second register frame
  // ****************************************************
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_DISABLE_FORWARD = 16'h0180;
  localparam logic [15:0] OFS_DEACTIVATE = 16'h0380;
  localparam logic [15:0] OFS_SW_TRIGGER = 16'h0c00;
  localparam logic [15:0] OFS_PERIPH_TRIGGER = 16'h0c04;

  // ****************************************************
  // Field layout
  // ****************************************************
  localparam int NUM_IRQ = 32;
  localparam int NUM_SGI = 16;
  localparam int SGI_LSB = 0;
  localparam int PPI_LSB = 16;
  localparam int TRIG_FIELD_W = 2;
  localparam int TRIG_TYPE_BIT = 1;

  // ****************************************************
  // Reset values and timing
  // ****************************************************
  localparam logic [31:0] RST_ACTIVE = 32'h0000_0000;
  localparam logic [31:0] RST_FORWARD = 32'h0000_0000;
  localparam logic [15:0] RST_PPI_EDGE = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam int PROPAGATE_CYCLES = 2;
  localparam int PROP_CNT_W = 2;

endpackage : pis_pkg

// >>> src/pis_regs.sv
// Per-core private interrupt active, forwarding and trigger registers
`timescale 1ns/10ps
module pis_regs #(
  parameter logic [15:0] PPI_PROGRAMMABLE = 16'hffff, // Writable fields
  parameter logic [15:0] PPI_FIXED_EDGE = 16'h0000 // Value of fixed fields
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Synchronous reset
  input wire logic req, // Register access strobe
  input wire logic wr, // 1 write, 0 read
  input wire logic [15:0] addr, // Byte offset in frame
  input wire logic [31:0] wdata, // Write data
  input wire logic nonsecure, // Access is non-secure
  output logic [31:0] rdata, // Read data
  output logic rvalid, // Read data valid pulse
  input wire logic security_disable, // Single security state
  input wire logic affinity_secure, // Affinity routing, secure
  input wire logic affinity_nonsecure, // Affinity routing, non-secure
  input wire logic [31:0] group_status, // 1 = non-secure group 1
  input wire logic [31:0] group_modifier, // 1 = secure group 1
  input wire logic [31:0] activate, // Interrupt taken, sets active
  input wire logic [31:0] enable_forward, // Set forwarding enable
  output logic [31:0] active, // Active state per interrupt
  output logic [31:0] forward_en, // Forwarding to CPU interface
  output logic [31:0] edge_trig, // 1 edge, 0 level
  output logic write_pending_status // Disables still propagating
);

  // ****************************************************
  // Access qualification
  // ****************************************************

  logic [31:0] access_ok;
  logic [31:0] trig_ok;
  logic wr_disable;
  logic wr_deact;
  logic wr_sw_trig;
  logic wr_pp_trig;
  logic [31:0] disable_hits;
  logic [31:0] deact_hits;
  logic [15:0] pp_trig_wr;
  logic [15:0] pp_trig_val;
  logic [31:0] next_rdata;
  logic [31:0] sw_trig_rd;
  logic [31:0] pp_trig_rd;
  localparam int PROP_CNT_W_L = pis_pkg::PROP_CNT_W;

  logic [15:0] ppi_edge;
  logic [PROP_CNT_W_L-1:0] prop_cnt;

  // Bit usable by this access: routing on for the
  // interrupt's security state, and secure interrupts
  // hidden from non-secure accesses unless security off.
  function automatic logic [31:0] usable(
    input logic [31:0] grp,
    input logic ds,
    input logic are_s,
    input logic are_ns,
    input logic ns
  );
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < pis_pkg::NUM_IRQ; i++) begin
      if (ds || grp[i]) begin
        m[i] = are_ns;
      end else begin
        m[i] = are_s;
      end
      if (!ds && ns && !grp[i]) begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction : usable

  // Group modifier is unused for masking: both secure
  // group 0 and secure group 1 read as secure here.
  assign access_ok = usable(group_status, security_disable,
    affinity_secure, affinity_nonsecure, nonsecure);

  // Trigger fields follow the same masking; the
  // modifier term cancels out and changes nothing.
  assign trig_ok = usable(group_status & ~group_modifier
    | group_status, security_disable, affinity_secure,
    affinity_nonsecure, nonsecure);

  // ****************************************************
  // Address decode
  // ****************************************************

  always_comb begin
    wr_disable = 1'b0;
    wr_deact = 1'b0;
    wr_sw_trig = 1'b0;
    wr_pp_trig = 1'b0;
    if (req && wr && addr == pis_pkg::OFS_DISABLE_FORWARD) begin
      wr_disable = 1'b1;
    end else if (req && wr && addr == pis_pkg::OFS_DEACTIVATE) begin
      wr_deact = 1'b1;
    end else if (req && wr && addr == pis_pkg::OFS_SW_TRIGGER) begin
      wr_sw_trig = 1'b1;
    end else if (req && wr && addr == pis_pkg::OFS_PERIPH_TRIGGER) begin
      wr_pp_trig = 1'b1;
    end
  end

  // Writes of 0 and masked bits never touch active or forward_en
  assign disable_hits = wr_disable ? (wdata & access_ok)
                                   : 32'h0000_0000;
  assign deact_hits = wr_deact ? (wdata & access_ok)
                               : 32'h0000_0000;

  // ****************************************************
  // Active state
  // ****************************************************

  // A new activation in the clearing cycle wins, so an
  // interrupt taken at that moment is never lost.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active <= pis_pkg::RST_ACTIVE;
    end else begin
      active <= (active & ~deact_hits) | activate;
    end
  end

  // ****************************************************
  // Forwarding enable
  // ****************************************************

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      forward_en <= pis_pkg::RST_FORWARD;
    end else begin
      forward_en <= (forward_en & ~disable_hits)
                    | enable_forward;
    end
  end

  // ****************************************************
  // Write pending status
  // ****************************************************

  // Propagation is modelled as a fixed delay; a new
  // disable write restarts it so the flag never drops
  // before the latest write has settled.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prop_cnt <= '0;
    end else if (wr_disable) begin
      prop_cnt <= PROP_CNT_W_L'(pis_pkg::PROPAGATE_CYCLES);
    end else if (prop_cnt != '0) begin
      prop_cnt <= prop_cnt - PROP_CNT_W_L'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_pending_status <= 1'b0;
    end else if (wr_disable) begin
      write_pending_status <= 1'b1;
    end else begin
      write_pending_status <= prop_cnt > PROP_CNT_W_L'(1);
    end
  end

  // ****************************************************
  // Trigger configuration
  // ****************************************************

  generate
    for (genvar x = 0; x < pis_pkg::NUM_SGI; x++) begin : g_pp
      // Fixed fields keep their built-in method
      assign pp_trig_wr[x] = wr_pp_trig && PPI_PROGRAMMABLE[x]
        && trig_ok[pis_pkg::PPI_LSB + x];
      assign pp_trig_val[x] =
        wdata[pis_pkg::TRIG_FIELD_W * x
              + pis_pkg::TRIG_TYPE_BIT];
    end
  endgenerate

  // Software must disable before changing a field;
  // no interlock here, the new value applies two cycles after the write.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ppi_edge <= pis_pkg::RST_PPI_EDGE;
    end else begin
      ppi_edge <= (ppi_edge & ~pp_trig_wr)
                  | (pp_trig_val & pp_trig_wr);
    end
  end

  // Applied method: fixed fields use the built-in value once out of reset; reset loads level for all PPIs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      edge_trig <= {16'h0000, 16'hffff};
    end else begin
      edge_trig <= {(ppi_edge & PPI_PROGRAMMABLE)
                    | (PPI_FIXED_EDGE & ~PPI_PROGRAMMABLE),
                    16'hffff};
    end
  end

  // Writes to the software trigger register are
  // accepted and dropped: every bit is fixed.
  generate
    for (genvar x = 0; x < pis_pkg::NUM_SGI; x++) begin : g_rd
      assign sw_trig_rd[2*x] = 1'b0;
      assign sw_trig_rd[2*x+1] =
        trig_ok[pis_pkg::SGI_LSB + x];
      assign pp_trig_rd[2*x] = 1'b0;
      assign pp_trig_rd[2*x+1] =
        trig_ok[pis_pkg::PPI_LSB + x]
        && edge_trig[pis_pkg::PPI_LSB + x];
    end
  endgenerate

  // ****************************************************
  // Read path
  // ****************************************************

  always_comb begin
    next_rdata = pis_pkg::RST_RDATA;
    if (addr == pis_pkg::OFS_DISABLE_FORWARD) begin
      next_rdata = forward_en & access_ok;
    end else if (addr == pis_pkg::OFS_DEACTIVATE) begin
      next_rdata = active & access_ok;
    end else if (addr == pis_pkg::OFS_SW_TRIGGER) begin
      next_rdata = sw_trig_rd;
    end else if (addr == pis_pkg::OFS_PERIPH_TRIGGER) begin
      next_rdata = pp_trig_rd;
    end
  end

  // Unmapped offsets read zero; one answer per read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= pis_pkg::RST_RDATA;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req && !wr;
      if (req && !wr) begin
        rdata <= next_rdata;
      end
    end
  end

  // Instantiate once per core; nothing is shared
  // between copies.

endmodule : pis_regs

// >>> verification/pis_cpu_if.sv
// Model of the CPU interface that takes forwarded interrupts
`timescale 1ns/10ps
module pis_cpu_if (
  input wire logic clk, // System clock
  input wire logic [31:0] take, // Interrupts the core acknowledges
  input wire logic [31:0] forward_en, // Forwarded by the block
  output logic [31:0] activate // Acknowledge marks interrupt active
);
  // Only a forwarded interrupt can be acknowledged
  always_ff @(posedge clk) begin
    activate <= take & forward_en;
  end
endmodule : pis_cpu_if

// >>> verification/pis_chk.sv
// Assertion checker for the private interrupt state registers
`timescale 1ns/10ps
module pis_chk (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic req, // Strobe
  input wire logic wr, // Write
  input wire logic [15:0] addr, // Offset
  input wire logic [31:0] wdata, // Write data
  input wire logic nonsecure, // Non-secure access
  input wire logic [31:0] rdata, // Read data
  input wire logic rvalid, // Read valid
  input wire logic security_disable, // One security state
  input wire logic affinity_nonsecure, // Routing
  input wire logic [31:0] activate, // Sets active
  input wire logic [31:0] enable_forward, // Sets forwarding
  input wire logic [31:0] active, // Active
  input wire logic [31:0] forward_en, // Forwarding
  input wire logic [31:0] edge_trig, // Trigger
  input wire logic write_pending_status // Propagating
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic dwr;
  logic open;
  assign dwr = req && wr && addr == pis_pkg::OFS_DISABLE_FORWARD;
  assign open = !nonsecure && security_disable && affinity_nonsecure;
  sequence s_quiet;
    !dwr [*3];
  endsequence
  a_read_answer: assert property (req && !wr |=> rvalid)
    else $error("read not answered");
  a_no_spurious: assert property (!(req && !wr) |=> !rvalid && $stable(rdata))
    else $error("unrequested read answer");
  a_sgi_edge: assert property (edge_trig[15:0] == 16'hffff)
    else $error("software trigger not edge");
  a_act_sets: assert property (activate != 0 |=>
    (active & $past(activate)) == $past(activate))
    else $error("activate lost");
  a_fwd_sets: assert property (enable_forward != 0 |=>
    (forward_en & $past(enable_forward)) == $past(enable_forward))
    else $error("enable lost");
  a_wpend_rise: assert property (|($past(forward_en) & ~forward_en)
    |-> write_pending_status)
    else $error("pending status missing");
  a_wpend_drop: assert property (s_quiet |-> !write_pending_status)
    else $error("pending status stuck");
  a_deact_clr: assert property (req && wr && open && activate == 0 &&
    addr == pis_pkg::OFS_DEACTIVATE |=> (active & $past(wdata)) == 0)
    else $error("deactivate ignored");
  a_dis_clr: assert property (dwr && open && enable_forward == 0
    |=> (forward_en & $past(wdata)) == 0)
    else $error("disable ignored");
endmodule : pis_chk
bind pis_regs pis_chk u_chk (.clk, .rst_b, .req, .wr, .addr, .wdata,
  .nonsecure, .rdata, .rvalid, .security_disable, .affinity_nonsecure,
  .activate, .enable_forward, .active, .forward_en, .edge_trig,
  .write_pending_status);

// >>> verification/tb_pis_regs.sv
// Self-checking testbench for the private interrupt state registers
`timescale 1ns/10ps
module tb_pis_regs;
  logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, wr = 1'b0;
  logic nonsecure = 1'b0, sec_dis = 1'b1, aff_s = 1'b1, aff_ns = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0, grp = 32'h0, take = 32'h0, en = 32'h0, rd;
  logic [31:0] rdata, active, fwd, trig, act;
  logic rvalid, wps;
  int n_fail = 0, n_compared = 0;
  pis_regs dut (.clk, .rst_b, .req, .wr, .addr, .wdata, .nonsecure,
    .rdata, .rvalid, .security_disable(sec_dis), .affinity_secure(aff_s),
    .affinity_nonsecure(aff_ns), .group_status(grp),
    .group_modifier(32'h0), .activate(act), .enable_forward(en),
    .active, .forward_en(fwd), .edge_trig(trig),
    .write_pending_status(wps));
  pis_cpu_if u_cpu (.clk, .take, .forward_en(fwd), .activate(act));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic bus(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    req = 1'b0;
    if (!w) begin
      check("rvalid", 32'h1, {31'h0, rvalid});
      rd = rdata;
    end
  endtask : bus
  task automatic rchk(input string what, input logic [15:0] a,
    input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask : rchk
  task automatic fire(input logic [31:0] e, t);
    @(negedge clk);
    en = e;
    take = t;
    repeat (2) @(negedge clk);
    en = 32'h0;
    take = 32'h0;
  endtask : fire
  task automatic t_forward;
    fire(32'h8001_0001, 32'h0);
    rchk("fwd", pis_pkg::OFS_DISABLE_FORWARD, 32'h8001_0001);
    bus(1'b1, pis_pkg::OFS_DISABLE_FORWARD, 32'h0);
    check("fwd keep", 32'h8001_0001, fwd);
    bus(1'b1, pis_pkg::OFS_DISABLE_FORWARD, 32'h1);
    check("pending", 32'h1, {31'h0, wps});
    rchk("fwd cleared", pis_pkg::OFS_DISABLE_FORWARD, 32'h8001_0000);
    check("pending end", 32'h0, {31'h0, wps});
  endtask : t_forward
  task automatic t_active;
    fire(32'h0, 32'hffff_ffff);
    rchk("active", pis_pkg::OFS_DEACTIVATE, 32'h8001_0000);
    bus(1'b1, pis_pkg::OFS_DEACTIVATE, 32'h0001_0001);
    rchk("deact", pis_pkg::OFS_DEACTIVATE, 32'h8000_0000);
    check("active out", 32'h8000_0000, active);
  endtask : t_active
  task automatic t_trigger;
    bus(1'b1, pis_pkg::OFS_DISABLE_FORWARD, 32'h0003_0000);
    check("fwd before trig", 32'h8000_0000, fwd);
    bus(1'b1, pis_pkg::OFS_PERIPH_TRIGGER, 32'h5555_000a);
    rchk("ppi trig", pis_pkg::OFS_PERIPH_TRIGGER, 32'h0000_000a);
    check("applied", 32'h0003_ffff, trig);
    bus(1'b1, pis_pkg::OFS_SW_TRIGGER, 32'h0);
    rchk("sgi trig", pis_pkg::OFS_SW_TRIGGER, 32'haaaa_aaaa);
  endtask : t_trigger
  task automatic t_secure;
    sec_dis = 1'b0;
    grp = 32'h0000_00ff;
    nonsecure = 1'b1;
    rchk("ns active", pis_pkg::OFS_DEACTIVATE, 32'h0);
    rchk("ns sgi", pis_pkg::OFS_SW_TRIGGER, 32'h0000_aaaa);
    bus(1'b1, pis_pkg::OFS_PERIPH_TRIGGER, 32'h0);
    rchk("ns ppi", pis_pkg::OFS_PERIPH_TRIGGER, 32'h0);
    check("ns kept", 32'h0003_ffff, trig);
    nonsecure = 1'b0;
    aff_s = 1'b0;
    rchk("no route", pis_pkg::OFS_DISABLE_FORWARD, 32'h0);
    rchk("no route trig", pis_pkg::OFS_SW_TRIGGER, 32'h0000_aaaa);
    aff_s = 1'b1;
    sec_dis = 1'b1;
    grp = 32'h0;
  endtask : t_secure
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(negedge clk);
    check("reset trig", 32'h0000_ffff, trig);
    rst_b = 1'b1;
    t_forward();
    t_active();
    t_trigger();
    t_secure();
    rchk("unmapped", 16'h0184, 32'h0);
    summarize();
  end
  // Whole run needs under 200 cycles
  initial begin
    #5000;
    n_fail++;
    summarize();
  end
endmodule : tb_pis_regs
